// File: src/pllssc_pkg.sv
// constants, field layout and types for the pll and spread-spectrum control block
// Overview of operation
// [R1] each pll: normal 80-200, high 180-300 mhz
// [R2] fractional n/m when vco at most 250 mhz
// [R3] host: integer n/m above 250 mhz vco
// [R4] host: keep m no larger than n
// [R5] pll bypass routes input clock to switch a
// [R6] vco bypass powers pll down, m kept
// [R7] vco bypass output is input over m*p
// [R8] normal output is input times n/m over p
// [R9] loop settings derived from dividers, not host
// [R10] second pll has modulated and plain outputs
// [R11] center spread keeps mean phase of carrier
// [R12] modulated clock chosen via switch a source
// [R13] spread bypass forces modulated output low
// [R14] host: spread use needs vco at most 167
// [R15] center spread 0.1, 0.25 or 0.4 percent
// [R16] down spread 1, 1.5, 2 or 3 percent
// [R17] sweep rate 30 or 60 khz selectable
// [R18] triangular modulation profile each sweep
// [R19] two-bit slew field per output
// [R20] four-bit field sets multi-function pin roles
// [R21] address mode allows four devices per bus
// [R22] pin levels become low slave address bits
package pllssc_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int SSC_SLOW_HZ = 30_000;
   localparam int SSC_FAST_HZ = 60_000;
   localparam logic [11:0] SSC_HALF = 12'(CLK_HZ / SSC_SLOW_HZ / 2);
   localparam logic [11:0] SSC_STEP_SLOW = 12'h001;
   localparam logic [11:0] SSC_STEP_FAST = 12'(SSC_FAST_HZ / SSC_SLOW_HZ);
   localparam logic [39:0] VCO_NORM_MIN_KHZ = 40'h00_0001_3880;
   localparam logic [39:0] VCO_NORM_MAX_KHZ = 40'h00_0003_0d40;
   localparam logic [39:0] VCO_HIGH_MIN_KHZ = 40'h00_0002_bf20;
   localparam logic [39:0] VCO_HIGH_MAX_KHZ = 40'h00_0004_93e0;
   localparam logic [39:0] VCO_FRAC_MAX_KHZ = 40'h00_0003_d090;
   localparam logic [39:0] VCO_SSC_MAX_KHZ = 40'h00_0002_8c58;
   localparam logic [3:0] IDX_PLL1 = 4'h0;
   localparam logic [3:0] IDX_SSC = 4'h3;
   localparam logic [3:0] IDX_OUT1 = 4'h4;
   localparam logic [3:0] IDX_MFP = 4'ha;
   localparam logic [3:0] IDX_STATUS = 4'hb;
   localparam int NUM_REGS = 11;
   localparam int PLL_N_LSB = 9;
   localparam int PLL_RANGE_BIT = 21;
   localparam int PLL_VBYP_BIT = 22;
   localparam int PLL_PBYP_BIT = 23;
   localparam int SSC_DOWN_BIT = 0;
   localparam int SSC_AMT_LSB = 1;
   localparam int SSC_RATE_BIT = 3;
   localparam int SSC_BYP_BIT = 4;
   localparam int OUT_P_LSB = 3;
   localparam int OUT_SLEW_LSB = 10;
   localparam logic [31:0] PLL_MASK = 32'h00ff_ffff;
   localparam logic [31:0] SSC_MASK = 32'h0000_001f;
   localparam logic [31:0] OUT_MASK = 32'h0000_0fff;
   localparam logic [31:0] MFP_MASK = 32'h0000_000f;
   localparam logic [31:0] PLL_RST = 32'h0000_0201;
   localparam logic [31:0] SSC_RST = 32'h0000_0010;
   localparam logic [31:0] OUT_RST = 32'h0000_0008;
   localparam logic [3:0] MFP_ADDR_MODE = 4'hf;
   localparam logic [1:0] MFP_PD = 2'h0;
   localparam logic [1:0] MFP_BYP = 2'h1;
   localparam logic [1:0] MFP_CSEL = 2'h2;
   localparam logic [15:0] CTR_0P10 = 16'h000a;
   localparam logic [15:0] CTR_0P25 = 16'h0019;
   localparam logic [15:0] CTR_0P40 = 16'h0028;
   localparam logic [15:0] DN_1P0 = 16'h0064;
   localparam logic [15:0] DN_1P5 = 16'h0096;
   localparam logic [15:0] DN_2P0 = 16'h00c8;
   localparam logic [15:0] DN_3P0 = 16'h012c;
   typedef enum logic [2:0] {
      SRC_INPUT = 3'b000,
      SRC_PLL1 = 3'b001,
      SRC_PLL2 = 3'b010,
      SRC_PLL2_SSC = 3'b011,
      SRC_PLL3 = 3'b100
   } pllssc_src_t;
   typedef enum logic [1:0] {
      OST_ACTIVE = 2'b00,
      OST_LOW = 2'b01,
      OST_HIZ = 2'b10,
      OST_PD = 2'b11
   } pllssc_ostate_t;
endpackage

// File: src/pllssc_ctrl.sv
// register slave, pll mode control, spread modulation and pin roles
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
module pllssc_ctrl
   import pllssc_pkg::*;
#(
   parameter int REF_KHZ = 27000
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic multi_function_pin_low_i,
   input wire logic multi_function_pin_high_i,
   output logic [26:0] pll_m_o,
   output logic [35:0] pll_n_o,
   output logic [2:0] vco_range_select_o,
   output logic [2:0] vco_bypass_select_o,
   output logic [2:0] pll_bypass_o,
   output logic [2:0] pll_power_down_o,
   output logic [2:0] frac_enable_o,
   output logic [8:0] loop_code_o,
   output logic ssc_out_enable_o,
   output logic ssc_down_o,
   output logic [15:0] ssc_dev_o,
   output logic [17:0] switch_a_source_select_o,
   output logic [41:0] post_div_o,
   output logic [11:0] slew_rate_o,
   output logic [1:0] output_state_o,
   output logic clock_select_o,
   output logic div_bypass_o,
   output logic slave_addr_bit_zero_o,
   output logic slave_addr_bit_one_o
);

   logic [31:0] regs [0:NUM_REGS-1];
   logic wait_q;
   logic [31:0] rdata_q;
   logic [1:0] s0_sync;
   logic [1:0] s1_sync;
   logic [11:0] tri_q;
   logic dir_down;
   logic [15:0] dev_q;
   logic [2:0] pwd_q;
   logic [2:0] frac_q;
   logic [2:0] range_ok_q;
   logic [8:0] loop_q;
   logic ssc_ok_q;
   logic [1:0] ostate_q;
   logic csel_q;
   logic dbyp_q;
   logic ssc_en_q;
   logic addr0_q;
   logic addr1_q;

   // n * ref compared with khz * m, i.e. vco above khz
   function automatic logic vco_above(input logic [31:0] r, input logic [39:0] khz);
      logic [39:0] lhs;
      logic [39:0] rhs;
      lhs = 40'(r[PLL_N_LSB +: 12]) * 40'(REF_KHZ);
      rhs = khz * 40'(r[8:0]);
      return lhs > rhs;
   endfunction

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
      logic [31:0] be;
      be = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
            {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      return ((old & ~be) | (avs_writedata_i & be)) & mask;
   endfunction

   function automatic logic [31:0] reg_mask(input int i);
      return (i < int'(IDX_SSC)) ? PLL_MASK : (i == int'(IDX_SSC)) ? SSC_MASK :
             (i < int'(IDX_MFP)) ? OUT_MASK : MFP_MASK;
   endfunction

   function automatic logic [31:0] reg_rst(input int i);
      return (i < int'(IDX_SSC)) ? PLL_RST : (i == int'(IDX_SSC)) ? SSC_RST :
             (i < int'(IDX_MFP)) ? OUT_RST : 32'h0000_0000;
   endfunction

   // bus decode
   wire [3:0] idx = avs_address_i[5:2];
   wire in_map = (avs_address_i[7:6] == 2'h0) && (idx <= IDX_STATUS);
   wire req = avs_read_i | avs_write_i;
   wire commit_wr = avs_write_i & ~wait_q & in_map;
   wire [31:0] ssc_r = regs[IDX_SSC];
   wire [31:0] mfp_r = regs[IDX_MFP];
   wire [31:0] pll2_r = regs[IDX_PLL1 + 4'h1];
   wire ssc_byp = ssc_r[SSC_BYP_BIT];
   wire ssc_down = ssc_r[SSC_DOWN_BIT];
   wire [1:0] ssc_amt = ssc_r[SSC_AMT_LSB +: 2];
   wire s0 = s0_sync[1];
   wire s1 = s1_sync[1];

   // status word
   wire [31:0] status_w = {20'h0_0000, ostate_q, s1, s0, ssc_ok_q, ssc_out_enable_o,
                           range_ok_q, frac_q};
   wire [31:0] rd_word = !in_map ? 32'h0000_0000 :
                         (idx == IDX_STATUS) ? status_w : regs[idx];

   // single wait cycle per access, answer on second edge
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wait_q <= 1'b1;
      end
      else
      begin
         wait_q <= ~(req & wait_q);
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (avs_read_i & wait_q)
      begin
         rdata_q <= rd_word;
      end
   end

   // configuration storage
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            regs[i] <= reg_rst(i);
         end
      end
      else if (commit_wr && idx != IDX_STATUS)
      begin
         regs[idx] <= merge(regs[idx], reg_mask(int'(idx)));
      end
   end

   // pin synchronisers
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s0_sync <= 2'h0;
         s1_sync <= 2'h0;
      end
      else
      begin
         s0_sync <= {s0_sync[0], multi_function_pin_low_i};
         s1_sync <= {s1_sync[0], multi_function_pin_high_i};
      end
   end

   // per-pll derived settings
   logic [2:0] next_frac;
   logic [2:0] next_range_ok;
   logic [8:0] next_loop;
   always_comb
   begin
      next_frac = 3'h0;
      next_range_ok = 3'h0;
      next_loop = 9'h000;
      for (int p = 0; p < 3; p++)
      begin
         // [R2] fractional at or below limit
         next_frac[p] = ~vco_above(regs[p], VCO_FRAC_MAX_KHZ);
         // [R1] range window check
         if (regs[p][PLL_RANGE_BIT])
         begin
            next_range_ok[p] = ~vco_above(regs[p], VCO_HIGH_MAX_KHZ)
                               & vco_above(regs[p], VCO_HIGH_MIN_KHZ - 40'h1);
         end
         else
         begin
            next_range_ok[p] = ~vco_above(regs[p], VCO_NORM_MAX_KHZ)
                               & vco_above(regs[p], VCO_NORM_MIN_KHZ - 40'h1);
         end
         // [R9] loop code from n divider and range bit
         next_loop[p*3 +: 3] = {regs[p][PLL_RANGE_BIT],
                                (regs[p][PLL_N_LSB +: 12] > 12'h0ff),
                                (regs[p][PLL_N_LSB +: 12] > 12'h00f)};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         frac_q <= 3'h0;
         range_ok_q <= 3'h0;
         loop_q <= 9'h000;
         ssc_ok_q <= 1'b0;
      end
      else
      begin
         frac_q <= next_frac;
         range_ok_q <= next_range_ok;
         loop_q <= next_loop;
         ssc_ok_q <= ~vco_above(pll2_r, VCO_SSC_MAX_KHZ);
      end
   end

   // triangle sweep position
   wire [11:0] step = ssc_r[SSC_RATE_BIT] ? SSC_STEP_FAST : SSC_STEP_SLOW;
   logic [11:0] next_tri;
   logic next_dir;
   always_comb
   begin
      next_tri = tri_q;
      next_dir = dir_down;
      if (ssc_byp)
      begin
         next_tri = 12'h000;
         next_dir = 1'b0;
      end
      // [R18] up then down ramp
      else if (!dir_down)
      begin
         if (tri_q + step >= SSC_HALF)
         begin
            next_tri = SSC_HALF;
            next_dir = 1'b1;
         end
         else
         begin
            next_tri = tri_q + step;
         end
      end
      else
      begin
         if (tri_q <= step)
         begin
            next_tri = 12'h000;
            next_dir = 1'b0;
         end
         else
         begin
            next_tri = tri_q - step;
         end
      end
   end

   // [R17] rate sets ramp step
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tri_q <= 12'h000;
         dir_down <= 1'b0;
      end
      else
      begin
         tri_q <= next_tri;
         dir_down <= next_dir;
      end
   end

   // deviation peak in hundredths of a percent
   logic [15:0] peak;
   always_comb
   begin
      case ({ssc_down, ssc_amt})
         // [R15] center spread amounts
         3'b000: peak = CTR_0P10;
         3'b001: peak = CTR_0P25;
         3'b010: peak = CTR_0P40;
         3'b011: peak = CTR_0P40;
         // [R16] down spread amounts
         3'b100: peak = DN_1P0;
         3'b101: peak = DN_1P5;
         3'b110: peak = DN_2P0;
         3'b111: peak = DN_3P0;
         default: peak = 16'h0000;
      endcase
   end

   wire [27:0] prod = 28'(peak) * 28'(tri_q);
   wire [15:0] scaled = 16'(prod / 28'(SSC_HALF));
   // [R11] symmetric about zero, zero mean
   wire [15:0] ctr_dev = 16'(scaled << 1) - peak;
   // [R16] never above carrier
   wire [15:0] dn_dev = 16'h0000 - scaled;
   // [R13] modulation silenced in bypass
   wire [15:0] next_dev = ssc_byp ? 16'h0000 : (ssc_down ? dn_dev : ctr_dev);

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dev_q <= 16'h0000;
         ssc_en_q <= 1'b0;
      end
      else
      begin
         dev_q <= next_dev;
         ssc_en_q <= ~ssc_byp;
      end
   end

   // multi-function pin roles
   // [R20] field selects pin use
   wire addr_mode = (mfp_r[3:0] == MFP_ADDR_MODE);
   wire [1:0] low_role = mfp_r[1:0];
   wire hi_ctrl = ~mfp_r[3];
   wire pd_req = ~addr_mode & (low_role == MFP_PD) & ~s0;
   wire byp_req = ~addr_mode & (low_role == MFP_BYP) & ~s0;
   wire out_off = ~addr_mode & hi_ctrl & ~s1;
   wire [1:0] next_ostate = pd_req ? OST_PD :
                            (out_off & mfp_r[2]) ? OST_HIZ :
                            out_off ? OST_LOW : OST_ACTIVE;

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ostate_q <= OST_ACTIVE;
         csel_q <= 1'b0;
         dbyp_q <= 1'b0;
         addr0_q <= 1'b0;
         addr1_q <= 1'b0;
      end
      else
      begin
         ostate_q <= next_ostate;
         csel_q <= ~addr_mode & (low_role == MFP_CSEL) & s0;
         dbyp_q <= byp_req | pd_req;
         // [R21] [R22] pins as low address bits
         addr0_q <= addr_mode & s0;
         addr1_q <= addr_mode & s1;
      end
   end

   // [R6] vco bypass or pin power-down
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pwd_q <= 3'h0;
      end
      else
      begin
         for (int p = 0; p < 3; p++)
         begin
            pwd_q[p] <= regs[p][PLL_VBYP_BIT] | pd_req;
         end
      end
   end

   // register-sourced outputs
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_pll
         // [R6] [R7] [R8] m stays in path, n drives loop
         assign pll_m_o[g*9 +: 9] = regs[g][8:0];
         assign pll_n_o[g*12 +: 12] = regs[g][PLL_N_LSB +: 12];
         // [R1] speed range per pll
         assign vco_range_select_o[g] = regs[g][PLL_RANGE_BIT];
         assign vco_bypass_select_o[g] = regs[g][PLL_VBYP_BIT];
         // [R5] input straight to switch a
         assign pll_bypass_o[g] = regs[g][PLL_PBYP_BIT];
      end
      for (g = 0; g < 6; g++)
      begin : g_out
         // [R12] source select picks modulated clock
         assign switch_a_source_select_o[g*3 +: 3] = regs[IDX_OUT1 + 4'(g)][2:0];
         assign post_div_o[g*7 +: 7] = regs[IDX_OUT1 + 4'(g)][OUT_P_LSB +: 7];
         // [R19] two-bit slew per output
         assign slew_rate_o[g*2 +: 2] = regs[IDX_OUT1 + 4'(g)][OUT_SLEW_LSB +: 2];
      end
   endgenerate

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign pll_power_down_o = pwd_q;
   assign frac_enable_o = frac_q;
   assign loop_code_o = loop_q;
   // [R10] [R13] modulated output gated, plain one untouched
   assign ssc_out_enable_o = ssc_en_q;
   assign ssc_down_o = ssc_r[SSC_DOWN_BIT];
   assign ssc_dev_o = dev_q;
   assign output_state_o = ostate_q;
   assign clock_select_o = csel_q;
   assign div_bypass_o = dbyp_q;
   assign slave_addr_bit_zero_o = addr0_q;
   assign slave_addr_bit_one_o = addr1_q;

endmodule

// File: verif/pllssc_pin_model.sv
// board-side model driving the two multi-function pins
`timescale 1ns/1ns
module pllssc_pin_model
(
   input wire logic clock_i,
   input wire logic [1:0] strap_i,
   output logic multi_function_pin_low_o,
   output logic multi_function_pin_high_o
);
   logic [1:0] level = 2'h0;
   always @(posedge clock_i)
   begin
      level <= strap_i;
   end
   assign multi_function_pin_low_o = level[0];
   assign multi_function_pin_high_o = level[1];
endmodule

// File: verif/pllssc_ctrl_properties.sv
// port-level assertions for the pll control block
`timescale 1ns/1ns
module pllssc_ctrl_chk
#(
   parameter int REF_KHZ = 27000
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic multi_function_pin_low_i,
   input wire logic [26:0] pll_m_o,
   input wire logic [35:0] pll_n_o,
   input wire logic [2:0] vco_bypass_select_o,
   input wire logic [2:0] pll_power_down_o,
   input wire logic [2:0] frac_enable_o,
   input wire logic ssc_out_enable_o,
   input wire logic ssc_down_o,
   input wire logic [15:0] ssc_dev_o,
   input wire logic [11:0] slew_rate_o,
   input wire logic slave_addr_bit_zero_o,
   input wire logic slave_addr_bit_one_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic [1:0] calm;
   logic signed [15:0] dev;
   assign dev = ssc_dev_o;
   // cycles since the last write, capped
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         calm <= 2'h0;
      else if (avs_write_i)
         calm <= 2'h0;
      else if (calm != 2'h3)
         calm <= calm + 2'h1;
   end
   chk_frac_select: assert property (
      !$past(rst_i) && $stable(pll_m_o[8:0]) && $stable(pll_n_o[11:0]) |->
      frac_enable_o[0] == (int'(pll_n_o[11:0]) * REF_KHZ <= 250000 * int'(pll_m_o[8:0])))
      else $error("fractional enable does not match dividers");
   chk_bypass_power: assert property (
      (pll_power_down_o & $past(vco_bypass_select_o)) == $past(vco_bypass_select_o))
      else $error("vco bypass without power down");
   chk_ssc_off_zero: assert property (
      !ssc_out_enable_o && calm == 2'h3 |-> ssc_dev_o == 16'h0000)
      else $error("deviation not zero in spread bypass");
   chk_center_bound: assert property (
      ssc_out_enable_o && !ssc_down_o && calm == 2'h3 |-> dev >= -16'sd40 && dev <= 16'sd40)
      else $error("center deviation out of range");
   chk_down_bound: assert property (
      ssc_out_enable_o && ssc_down_o && calm == 2'h3 |-> dev <= 16'sd0 && dev >= -16'sd300)
      else $error("down deviation above carrier");
   chk_sweep_slope: assert property (
      calm == 2'h3 |-> dev - $past(dev) <= 16'sd2 && $past(dev) - dev <= 16'sd2)
      else $error("deviation step too large");
   chk_slew_hold: assert property (
      !avs_write_i |=> $stable(slew_rate_o))
      else $error("slew changed without write");
   chk_addr_pin: assert property (
      slave_addr_bit_zero_o |-> $past(multi_function_pin_low_i, 3))
      else $error("address bit without pin level");
   cover property (avs_read_i && !avs_waitrequest_o);
   cover property (ssc_out_enable_o && ssc_down_o && calm == 2'h3);
   cover property (slave_addr_bit_one_o);
endmodule
bind pllssc_ctrl pllssc_ctrl_chk #(.REF_KHZ(REF_KHZ)) chk_inst (.clock_i, .rst_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .multi_function_pin_low_i, .pll_m_o, .pll_n_o, .vco_bypass_select_o, .pll_power_down_o,
   .frac_enable_o, .ssc_out_enable_o, .ssc_down_o, .ssc_dev_o, .slew_rate_o, .slave_addr_bit_zero_o,
   .slave_addr_bit_one_o);

// File: verif/pllssc_ctrl_tb.sv
// self-checking bench for the pll control block
`timescale 1ns/1ns
module pllssc_ctrl_tb
   import pllssc_pkg::*;
;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [1:0] strap = 2'h3;
   logic pin_low, pin_high, avs_waitrequest_o, ssc_out_enable_o, ssc_down_o, clock_select_o, div_bypass_o;
   logic slave_addr_bit_zero_o, slave_addr_bit_one_o;
   logic [31:0] avs_readdata_o;
   logic [26:0] pll_m_o;
   logic [35:0] pll_n_o;
   logic [2:0] vco_range_select_o, vco_bypass_select_o, pll_bypass_o, pll_power_down_o, frac_enable_o;
   logic [8:0] loop_code_o;
   logic [15:0] ssc_dev_o;
   logic [17:0] switch_a_source_select_o;
   logic [41:0] post_div_o;
   logic [11:0] slew_rate_o;
   logic [1:0] output_state_o;
   int bad_count = 0;
   int comparisons = 0;
   always #5 clock_i = ~clock_i;
   pllssc_pin_model pin_model (.clock_i, .strap_i(strap), .multi_function_pin_low_o(pin_low),
      .multi_function_pin_high_o(pin_high));
   pllssc_ctrl #(.REF_KHZ(27000)) uut (.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .multi_function_pin_low_i(pin_low), .multi_function_pin_high_i(pin_high), .pll_m_o, .pll_n_o,
      .vco_range_select_o, .vco_bypass_select_o, .pll_bypass_o, .pll_power_down_o, .frac_enable_o, .loop_code_o,
      .ssc_out_enable_o, .ssc_down_o, .ssc_dev_o, .switch_a_source_select_o, .post_div_o, .slew_rate_o,
      .output_state_o, .clock_select_o, .div_bypass_o, .slave_addr_bit_zero_o, .slave_addr_bit_one_o);
   task automatic conclude();
      $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // one bus request held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 64);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (avs_waitrequest_o !== 1'b0)
      begin
         bad_count++;
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   task automatic reset_values();
      rd_check(8'h00, PLL_RST);
      rd_check(8'h0c, SSC_RST);
      rd_check(8'h10, OUT_RST);
      rd_check(8'h28, 32'h0);
      wr(8'h30, 32'hffff_ffff);
      rd_check(8'h30, 32'h0);
   endtask
   task automatic pll_modes();
      wr(8'h00, {8'h00, 3'b000, 12'd81, 9'd16});
      settle(2);
      check(32'(pll_m_o[8:0]), 32'd16);
      check(32'(pll_n_o[11:0]), 32'd81);
      check(32'(frac_enable_o[0]), 32'h1);
      check(32'(loop_code_o[2:0]), 32'h1);
      wr(8'h00, {8'h00, 3'b001, 12'd10, 9'd1});
      settle(2);
      check(32'(frac_enable_o[0]), 32'h0);
      check(32'(vco_range_select_o), 32'h1);
      check(32'(loop_code_o[2:0]), 32'h4);
      wr(8'h04, {8'h00, 3'b010, 12'd1, 9'd8});
      settle(2);
      check(32'(pll_power_down_o), 32'h2);
      check(32'(pll_m_o[17:9]), 32'd8);
      wr(8'h08, {8'h00, 3'b100, 12'd1, 9'd1});
      settle(2);
      check(32'({pll_bypass_o, pll_power_down_o}), 32'h22);
   endtask
   task automatic ssc_sweep();
      int pk [8] = '{10, 25, 40, 40, 100, 150, 200, 300};
      int lo;
      int hi;
      int sum;
      int v;
      logic [31:0] q;
      for (int k = 0; k < 8; k++)
      begin
         wr(8'h0c, {27'h0, 1'b0, 1'(k), 2'(k), 1'(k >> 2)});
         settle(3);
         lo = 0;
         hi = 0;
         sum = 0;
         repeat (3332)
         begin
            @(posedge clock_i);
            v = $signed(ssc_dev_o);
            sum = sum + v;
            if (v < lo)
               lo = v;
            if (v > hi)
               hi = v;
         end
         check(32'(lo), 32'(-pk[k]));
         check(32'(hi), k < 4 ? 32'(pk[k]) : 32'h0);
         check(32'(k >= 4 || (sum / 3332 >= -1 && sum / 3332 <= 1)), 32'h1);
         check(32'(ssc_out_enable_o), 32'h1);
      end
      xfer(1'b0, 8'h2c, 32'h0, q);
      check(32'(q[7:6]), 32'h3);
      wr(8'h0c, 32'h10);
      settle(3);
      check({15'h0, ssc_out_enable_o, ssc_dev_o}, 32'h0);
   endtask
   task automatic outputs();
      for (int i = 0; i < 6; i++)
      begin
         wr(8'(16 + 4 * i), {20'h0, 2'(i), 7'(i + 1), 3'(i % 5)});
         settle(1);
         check(32'(slew_rate_o[2 * i +: 2]), 32'(i % 4));
         check(32'(switch_a_source_select_o[3 * i +: 3]), 32'(i % 5));
         check(32'(post_div_o[7 * i +: 7]), 32'(i + 1));
      end
   endtask
   task automatic pins();
      wr(8'h28, 32'hf);
      strap <= 2'b01;
      settle(5);
      check(32'({slave_addr_bit_one_o, slave_addr_bit_zero_o}), 32'h1);
      strap <= 2'b10;
      settle(5);
      check(32'({slave_addr_bit_one_o, slave_addr_bit_zero_o}), 32'h2);
      wr(8'h28, 32'h2);
      strap <= 2'b01;
      settle(5);
      check(32'({slave_addr_bit_one_o, slave_addr_bit_zero_o, clock_select_o}), 32'h1);
      check(32'(output_state_o), 32'h1);
      wr(8'h28, 32'h0);
      strap <= 2'b00;
      settle(5);
      check(32'({pll_power_down_o, output_state_o, div_bypass_o}), 32'h3f);
   endtask
   initial
   begin
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      reset_values();
      pll_modes();
      ssc_sweep();
      outputs();
      pins();
      conclude();
   end
endmodule
